// ===== chp_defines.svh
`ifndef CHP_DEFINES_SVH
`define CHP_DEFINES_SVH

// ****************************************************************
// Widths of the host bus
// ****************************************************************
`define CHP_DATA_W 8
`define CHP_ADDR_W 6
// Address pin that doubles as the external wakeup line
`define CHP_AWAKE_BIT 5

// ****************************************************************
// Synchroniser layout: bit positions inside the synchronised vector
// ****************************************************************
`define CHP_SYNC_W 20
`define CHP_SY_BUS_LSB 0
`define CHP_SY_ADDR_LSB 8
`define CHP_SY_CS 14
`define CHP_SY_WR 15
`define CHP_SY_RD 16
`define CHP_SY_ALE 17
`define CHP_SY_RST 18
`define CHP_SY_STYLE 19
// Reset value: active-low strobes idle high, everything else low
`define CHP_SYNC_RST_VAL 20'h1c000

// ****************************************************************
// Timing
// ****************************************************************
`define CHP_CLK_PERIOD_NS 8
// Width of the reset pulse driven out after a wakeup edge
`define CHP_RST_PULSE_NS 500
`define CHP_RST_PULSE_CYC ((`CHP_RST_PULSE_NS + `CHP_CLK_PERIOD_NS - 1) / `CHP_CLK_PERIOD_NS)
`define CHP_PULSE_CNT_W 16
// Cycles the synchronised pin still shows our own pulse after release
`define CHP_PULSE_TAIL 16'h0002

`endif

// ===== chp_pkg.sv
package chp_pkg;

    // ****************************************************************
    // Access sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        CHP_ST_IDLE = 2'b00,  // No access in progress
        CHP_ST_READ = 2'b01,  // Read strobe held, bus driven
        CHP_ST_WRITE = 2'b10  // Write strobe held, data sampled
    } chp_state_t;

    // ****************************************************************
    // Bus style strap
    // ****************************************************************
    typedef enum logic {
        CHP_STYLE_LATCH = 1'b0,  // Separate read and write strobes
        CHP_STYLE_STROBE = 1'b1  // Data strobe plus direction line
    } chp_style_t;

endpackage : chp_pkg

// ===== chp_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for a vector of pin inputs
module chp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Asynchronous pins and their synchronised copy
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;  // First stage, read only by the second
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;  // Second stage, safe to use
    logic [WIDTH-1:0] sync_d;

    // Next values: plain shift, frozen while the enable is low
    always_comb begin
        meta_d = meta_q;
        sync_d = sync_q;
        if (ce) begin
            meta_d = pin_in;
            sync_d = meta_q;
        end
    end

    // Register stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule // chp_sync

`default_nettype wire

// ===== chp_host_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "chp_defines.svh"

module chp_host_port #(
    parameter int DATA_W = `CHP_DATA_W,
    parameter int ADDR_W = `CHP_ADDR_W,
    parameter int RST_PULSE_CYC = `CHP_RST_PULSE_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Host bus pins
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic addr_latch_en,
    input wire logic bus_style_strobe,
    input wire logic [ADDR_W-1:0] addr_pins,
    input wire logic [DATA_W-1:0] bus_in,
    output logic [DATA_W-1:0] bus_out,
    output logic bus_oe,
    // Open-drain interrupt request pin
    output logic irq_out_n,
    output logic irq_out_oe,
    // Two-way reset pin
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    // Device side: configuration and status
    input wire logic terminal_mode_en,
    input wire logic irq_pending,
    input wire logic wakeup_ack,
    output logic wakeup_flag,
    output logic core_reset,
    output chp_pkg::chp_state_t access_state,
    // Device side: register access
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata
);

    import chp_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The synchroniser layout is fixed for an 8-bit bus and six address pins
    if (DATA_W != 8 || ADDR_W != 6) begin : g_bad_width
        $error("chp_host_port: bus widths must be 8 data and 6 address bits");
    end
    if (RST_PULSE_CYC < 1 || RST_PULSE_CYC > (1 << `CHP_PULSE_CNT_W) - 3) begin : g_bad_pulse
        $error("chp_host_port: reset pulse length out of counter range");
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [`CHP_SYNC_W-1:0] pins_raw;  // All asynchronous pins in one vector
    logic [`CHP_SYNC_W-1:0] pins_s;  // Their synchronised copy

    assign pins_raw = {bus_style_strobe, reset_pin_in, addr_latch_en, read_strobe_n,
                       write_strobe_n, chip_select_n, addr_pins, bus_in};

    chp_sync #(
        .WIDTH(`CHP_SYNC_W),
        .RST_VAL(`CHP_SYNC_RST_VAL)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pin_in(pins_raw),
        .sync_out(pins_s)
    );

    // Named views of the synchronised pins
    logic [DATA_W-1:0] bus_s;
    logic [ADDR_W-1:0] addr_s;
    logic cs_n_s;
    logic wr_n_s;  // Doubles as direction line in strobe style
    logic rd_n_s;  // Doubles as data strobe in strobe style
    logic ale_s;
    logic rst_pin_s;
    logic style_s;

    assign bus_s = pins_s[`CHP_SY_BUS_LSB +: DATA_W];
    assign addr_s = pins_s[`CHP_SY_ADDR_LSB +: ADDR_W];
    assign cs_n_s = pins_s[`CHP_SY_CS];
    assign wr_n_s = pins_s[`CHP_SY_WR];
    assign rd_n_s = pins_s[`CHP_SY_RD];
    assign ale_s = pins_s[`CHP_SY_ALE];
    assign rst_pin_s = pins_s[`CHP_SY_RST];
    assign style_s = pins_s[`CHP_SY_STYLE];

    // ****************************************************************
    // Strobe decode
    // ****************************************************************
    // Returns 1 when the pin levels request an access of the given kind
    function automatic logic strobe_req(input logic style, input logic want_read,
                                        input logic wr_n, input logic rd_n);
        logic hit;
        hit = 1'b0;
        if (style == CHP_STYLE_STROBE) begin
            // Data strobe low, direction high for read, low for write
            hit = !rd_n && (wr_n == want_read);
        end else begin
            // Separate active-low strobes
            hit = want_read ? !rd_n : !wr_n;
        end
        return hit;
    endfunction

    logic selected;  // Chip select held low
    logic rd_req;  // Read strobe active while selected
    logic wr_req;  // Write strobe active while selected

    // Both styles share the same eight data lines and the same sequencer
    assign selected = !cs_n_s;
    assign rd_req = selected && strobe_req(style_s, 1'b1, wr_n_s, rd_n_s);
    assign wr_req = selected && strobe_req(style_s, 1'b0, wr_n_s, rd_n_s);

    // ****************************************************************
    // Address path
    // ****************************************************************
    logic mux_mode_q;  // Latch line has been seen high since reset
    logic mux_mode_d;
    logic [ADDR_W-1:0] mux_addr_q;  // Address taken from the shared lines
    logic [ADDR_W-1:0] mux_addr_d;
    logic [ADDR_W-1:0] pin_addr;  // Address pins, wakeup bit masked in terminal mode
    logic [ADDR_W-1:0] cur_addr;  // Address to use for the next access

    // Latch activity decides the addressing; a host that ties it low stays
    // non-multiplexed, so the choice is sticky until the next reset
    always_comb begin
        mux_mode_d = mux_mode_q;
        mux_addr_d = mux_addr_q;
        if (ale_s) begin
            mux_mode_d = 1'b1;
            mux_addr_d = bus_s[ADDR_W-1:0];
        end
        // Otherwise the last latched value holds
    end

    always_comb begin
        pin_addr = addr_s;
        // In terminal mode the top pin is the wakeup line, not an address bit
        if (terminal_mode_en) begin
            pin_addr[`CHP_AWAKE_BIT] = 1'b0;
        end
        cur_addr = mux_mode_q ? mux_addr_q : pin_addr;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mux_mode_q <= 1'b0;
            mux_addr_q <= '0;
        end else if (ce) begin
            mux_mode_q <= mux_mode_d;
            mux_addr_q <= mux_addr_d;
        end
    end

    // ****************************************************************
    // Access sequencer
    // ****************************************************************
    chp_state_t state_q;
    chp_state_t state_d;
    logic [ADDR_W-1:0] addr_q;  // Address held for the whole access
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] wdata_q;  // Last data seen under the write strobe
    logic [DATA_W-1:0] wdata_d;
    logic [DATA_W-1:0] rdata_q;  // Read data presented on the bus
    logic [DATA_W-1:0] rdata_d;
    logic rd_load_q;  // Read data arrives the cycle after the read pulse
    logic rd_load_d;
    logic reg_wr_q;
    logic reg_wr_d;
    logic reg_rd_q;
    logic reg_rd_d;
    logic bus_oe_q;
    logic bus_oe_d;

    // Write data is sampled every cycle under the strobe and committed when
    // the strobe goes away; data and strobes share one synchroniser, so the
    // last sample taken with the strobe active is a valid one
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        rd_load_d = 1'b0;
        reg_wr_d = 1'b0;
        reg_rd_d = 1'b0;
        bus_oe_d = 1'b0;
        if (rd_load_q) begin
            rdata_d = reg_rdata;
        end
        case (state_q)
            CHP_ST_IDLE: begin
                if (rd_req) begin
                    // Start a read: fetch the register next cycle, drive from the cycle after
                    addr_d = cur_addr;
                    reg_rd_d = 1'b1;
                    rd_load_d = 1'b1;
                    state_d = CHP_ST_READ;
                end else if (wr_req) begin
                    addr_d = cur_addr;
                    wdata_d = bus_s;
                    state_d = CHP_ST_WRITE;
                end
            end
            CHP_ST_READ: begin
                if (rd_req) begin
                    bus_oe_d = 1'b1;
                end else begin
                    // Strobe or select released: stop driving at once
                    state_d = CHP_ST_IDLE;
                end
            end
            CHP_ST_WRITE: begin
                if (wr_req) begin
                    wdata_d = bus_s;
                end else begin
                    // End of the strobe commits the captured byte
                    reg_wr_d = 1'b1;
                    state_d = CHP_ST_IDLE;
                end
            end
            default: begin
                state_d = CHP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= CHP_ST_IDLE;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            rd_load_q <= 1'b0;
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            bus_oe_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rd_load_q <= rd_load_d;
            reg_wr_q <= reg_wr_d;
            reg_rd_q <= reg_rd_d;
            bus_oe_q <= bus_oe_d;
        end
    end

    // ****************************************************************
    // Wakeup, reset pin and interrupt
    // ****************************************************************
    logic awake_dly_q;  // Previous synchronised wakeup level
    logic awake_dly_d;
    logic awake_fall;  // Falling edge on the wakeup line
    logic wake_q;  // Sticky wakeup event, cleared by the device core
    logic wake_d;
    logic [`CHP_PULSE_CNT_W-1:0] pulse_cnt_q;  // Pulse cycles left plus the mask tail
    logic [`CHP_PULSE_CNT_W-1:0] pulse_cnt_d;
    logic core_rst_q;
    logic core_rst_d;

    assign awake_fall = terminal_mode_en && awake_dly_q && !addr_s[`CHP_AWAKE_BIT];

    always_comb begin
        awake_dly_d = addr_s[`CHP_AWAKE_BIT];
        pulse_cnt_d = pulse_cnt_q;
        wake_d = wake_q;
        // Clear first, so an edge in the same cycle still sets the flag
        if (wakeup_ack) begin
            wake_d = 1'b0;
        end
        if (awake_fall) begin
            wake_d = 1'b1;
            pulse_cnt_d = RST_PULSE_CYC[`CHP_PULSE_CNT_W-1:0] + `CHP_PULSE_TAIL;
        end else if (pulse_cnt_q != '0) begin
            pulse_cnt_d = pulse_cnt_q - 1'b1;
        end
        // Dropping terminal mode ends the pulse but keeps the mask tail
        if (!terminal_mode_en && pulse_cnt_d > `CHP_PULSE_TAIL) begin
            pulse_cnt_d = `CHP_PULSE_TAIL;
        end
        // The pin reads back our own pulse, so ignore it until the sync drains
        core_rst_d = rst_pin_s && (pulse_cnt_q == '0);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awake_dly_q <= 1'b0;
            wake_q <= 1'b0;
            pulse_cnt_q <= '0;
            core_rst_q <= 1'b0;
        end else if (ce) begin
            awake_dly_q <= awake_dly_d;
            wake_q <= wake_d;
            pulse_cnt_q <= pulse_cnt_d;
            core_rst_q <= core_rst_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Open drain: output level is always low, only the enable moves
    assign irq_out_n = 1'b0;
    assign irq_out_oe = irq_pending || wake_q;
    // Reset pin driven high only for the wakeup pulse in terminal mode
    assign reset_pin_out = 1'b1;
    assign reset_pin_oe = (pulse_cnt_q > `CHP_PULSE_TAIL);
    assign bus_out = rdata_q;
    assign bus_oe = bus_oe_q;
    assign wakeup_flag = wake_q;
    assign core_reset = core_rst_q;
    assign access_state = state_q;
    assign reg_addr = addr_q;
    assign reg_wdata = wdata_q;
    assign reg_wr = reg_wr_q;
    assign reg_rd = reg_rd_q;

endmodule // chp_host_port

`default_nettype wire

// ===== chp_host_port_asserts.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Port checker for the host bus block
// ****************************************************************
module chp_host_port_asserts #(
    parameter int RST_PULSE_CYC = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Configuration and status
    input wire logic terminal_mode_en,
    input wire logic irq_pending,
    input wire logic wakeup_flag,
    input wire logic core_reset,
    input wire chp_pkg::chp_state_t access_state,
    // Pins
    input wire logic [5:0] addr_pins,
    input wire logic [7:0] bus_out,
    input wire logic bus_oe,
    input wire logic irq_out_n,
    input wire logic irq_out_oe,
    input wire logic reset_pin_in,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    // Register side
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata
);
    import chp_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [15:0] hi_cnt_q;  // Cycles the reset pin has been driven
    logic [15:0] hi_cnt_d;

    // Length counter: a plain repetition cannot take a parameter count
    always_comb begin
        hi_cnt_d = reset_pin_oe ? hi_cnt_q + 16'h0001 : 16'h0000;
    end

    // Registers only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hi_cnt_q <= 16'h0000;
        end else begin
            hi_cnt_q <= hi_cnt_d;
        end
    end

    a_irq_level: assert property (irq_out_oe == (irq_pending || wakeup_flag))
        else $error("interrupt line does not follow pending state");
    a_irq_open_drain: assert property (irq_out_oe |-> !irq_out_n)
        else $error("interrupt line driven high");
    a_bus_read_only: assert property (bus_oe |-> access_state == CHP_ST_READ)
        else $error("data lines driven outside a read");
    a_read_data: assert property (reg_rd |=> ##1 (bus_oe && bus_out == $past(reg_rdata)))
        else $error("read data not presented on data lines");
    a_strobe_pulse: assert property ((reg_rd || reg_wr) |=> !(reg_rd || reg_wr))
        else $error("register strobe longer than one cycle");
    a_core_reset_follow: assert property (($rose(reset_pin_in) && !reset_pin_oe) |-> ##3 core_reset)
        else $error("reset pin did not reset the core");
    a_wake_flag_set: assert property (($fell(addr_pins[5]) && terminal_mode_en) |-> ##3 wakeup_flag)
        else $error("wakeup edge not flagged");
    a_wake_pulse_out: assert property ($rose(wakeup_flag) |-> reset_pin_oe && reset_pin_out)
        else $error("wakeup gave no reset pulse");
    a_no_wake_idle: assert property (!terminal_mode_en |-> !$rose(wakeup_flag))
        else $error("wakeup flagged outside terminal mode");
    a_pulse_length: assert property ($fell(reset_pin_oe) |-> hi_cnt_q == 16'(RST_PULSE_CYC))
        else $error("reset pulse length wrong");
    a_own_pulse_quiet: assert property (($fell(reset_pin_oe) && !reset_pin_in) |-> (!core_reset) [*3])
        else $error("own reset pulse reached the core");

endmodule // chp_host_port_asserts

bind chp_host_port chp_host_port_asserts #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (
    .clk(clk), .nrst(nrst), .terminal_mode_en(terminal_mode_en), .irq_pending(irq_pending),
    .wakeup_flag(wakeup_flag), .core_reset(core_reset), .access_state(access_state),
    .addr_pins(addr_pins), .bus_out(bus_out), .bus_oe(bus_oe), .irq_out_n(irq_out_n),
    .irq_out_oe(irq_out_oe), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata)
);

`default_nettype wire

// ===== chp_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Host processor model on the 8-bit parallel bus
// ****************************************************************
module chp_host_model (
    // Clock
    input wire logic clk,
    // Control pins toward the device
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic addr_latch_en,
    output logic bus_style_strobe,
    output logic [5:0] addr_pins,
    // Shared data lines
    output logic [7:0] bus_in,
    input wire logic [7:0] bus_out,
    input wire logic bus_oe
);
    logic host_oe = 1'b0;  // Host drives the data lines
    logic [7:0] host_d = 8'h00;  // Value the host drives
    logic idle_q = 1'b0;  // Floating-line pattern

    // No pull on the data lines: a released bus must never look like data
    always_ff @(posedge clk) begin
        idle_q <= ~idle_q;
    end

    // Wire level from both parties' enables
    assign bus_in = bus_oe ? bus_out : (host_oe ? host_d : {8{idle_q}});

    // Idle levels at time zero
    initial begin
        chip_select_n = 1'b1;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        addr_latch_en = 1'b0;
        bus_style_strobe = 1'b0;
        addr_pins = 6'h20;
    end

    // One access; strap changes only while no access is open
    task automatic xfer(input logic sty, input logic mux, input logic rd, input logic csel,
                        input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        bus_style_strobe = sty;
        if (mux) begin
            // Address on the shared lines while the latch line is high
            addr_latch_en = 1'b1;
            host_oe = 1'b1;
            host_d = {2'b00, a};
            repeat (3) @(posedge clk);
            #1;
            addr_latch_en = 1'b0;
            repeat (3) @(posedge clk);
            #1;
        end
        chip_select_n = !csel;
        addr_pins = mux ? {1'b1, 5'($urandom)} : a;
        write_strobe_n = rd;
        read_strobe_n = sty ? 1'b0 : !rd;
        host_oe = !rd;
        host_d = d;
        repeat (8) @(posedge clk);
        q = bus_in;
        #1;
        // Strobe rise closes the access
        chip_select_n = 1'b1;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        host_oe = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask

    // External awake line level
    task automatic awake(input logic v);
        @(posedge clk);
        #1;
        addr_pins[5] = v;
    endtask

endmodule // chp_host_model

`default_nettype wire

// ===== chp_host_port_tb.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Testbench for the host bus block
// ****************************************************************
module chp_host_port_tb;
    import chp_pkg::*;

    localparam int PULSE = 4;  // Short reset pulse keeps the run brief
    logic clk, nrst, ext_rst, terminal_mode_en, irq_pending, wakeup_ack;
    logic chip_select_n, write_strobe_n, read_strobe_n, addr_latch_en, bus_style_strobe;
    logic [5:0] addr_pins, reg_addr, ra, wa, a;
    logic [7:0] bus_in, bus_out, reg_wdata, reg_rdata, wd, d, q;
    logic bus_oe, irq_out_n, irq_out_oe, reset_pin_in, reset_pin_out, reset_pin_oe;
    logic wakeup_flag, core_reset, reg_wr, reg_rd, rd, cs, ce;
    chp_state_t access_state;
    int n_rd = 0, n_wr = 0, n0r, n0w, cnt, compares = 0, err_total = 0;

    // Core register contents as seen by the bench
    function automatic logic [7:0] core_data(input logic [5:0] adr);
        return {adr, 2'b10} ^ 8'h3c;
    endfunction

    assign reg_rdata = core_data(reg_addr);
    // Reset pin wire: our pulse or the external source
    assign reset_pin_in = reset_pin_oe ? reset_pin_out : ext_rst;

    chp_host_model host (
        .clk(clk), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .addr_latch_en(addr_latch_en),
        .bus_style_strobe(bus_style_strobe), .addr_pins(addr_pins), .bus_in(bus_in),
        .bus_out(bus_out), .bus_oe(bus_oe)
    );

    chp_host_port #(.RST_PULSE_CYC(PULSE)) dut (
        .clk(clk), .nrst(nrst), .ce(ce), .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .addr_latch_en(addr_latch_en), .bus_style_strobe(bus_style_strobe),
        .addr_pins(addr_pins), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
        .irq_out_n(irq_out_n), .irq_out_oe(irq_out_oe), .reset_pin_in(reset_pin_in),
        .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .terminal_mode_en(terminal_mode_en), .irq_pending(irq_pending),
        .wakeup_ack(wakeup_ack), .wakeup_flag(wakeup_flag), .core_reset(core_reset),
        .access_state(access_state), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Register-side strobe monitor
    always @(posedge clk) begin
        if (reg_rd === 1'b1) begin
            n_rd++;
            ra = reg_addr;
        end
        if (reg_wr === 1'b1) begin
            n_wr++;
            wa = reg_addr;
            wd = reg_wdata;
        end
    end

    // One comparison
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic results();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Bounded wait on wakeup flag (sel 0) or core reset (sel 1)
    task automatic wait_for(input int sel, input logic v);
        int i;
        for (i = 0; i < 12; i++) begin
            if ((sel == 0 ? wakeup_flag : core_reset) === v) break;
            @(posedge clk);
            #1;
        end
        check("wait_level", {7'h00, sel == 0 ? wakeup_flag : core_reset}, {7'h00, v});
        if (i == 12) results();
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        results();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        ext_rst = 1'b0;
        terminal_mode_en = 1'b0;
        irq_pending = 1'b0;
        wakeup_ack = 1'b0;
        void'($urandom(91));
        repeat (12) @(posedge clk);
        #1 nrst = 1'b1;
        // Addressing: pins then multiplexed, since latch mode is sticky; both bus styles in each
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 6; k++) begin
                a = (k == 0) ? 6'h3f : (k == 1) ? 6'h00 : 6'($urandom);
                d = 8'($urandom);
                rd = (k < 2) ? k[0] : 1'($urandom);
                cs = (k != 5);
                n0r = n_rd;
                n0w = n_wr;
                host.xfer(m[0], m[1], rd, cs, a, d, q);
                check("rd_count", 8'(n_rd - n0r), {7'h00, rd & cs});
                check("wr_count", 8'(n_wr - n0w), {7'h00, !rd & cs});
                if (cs && rd) begin
                    check("rdata", q, core_data(a));
                    check("rd_addr", {2'b00, ra}, {2'b00, a});
                end
                if (cs && !rd) begin
                    check("wdata", wd, d);
                    check("wr_addr", {2'b00, wa}, {2'b00, a});
                end
                check("bus_release", {7'h00, bus_oe}, 8'h00);
            end
        end
        // Enable low freezes the port: a whole access leaves no trace
        ce = 1'b0;
        n0r = n_rd;
        n0w = n_wr;
        host.xfer(1'b1, 1'b1, 1'b0, 1'b1, 6'h15, 8'h5a, q);
        check("ce_frozen", 8'((n_rd - n0r) + (n_wr - n0w)), 8'h00);
        ce = 1'b1;
        // Interrupt level
        @(posedge clk);
        #1 irq_pending = 1'b1;
        #1 check("irq_on", {6'h00, irq_out_n, irq_out_oe}, 8'h01);
        @(posedge clk);
        #1 irq_pending = 1'b0;
        // Wakeup edge in terminal mode
        terminal_mode_en = 1'b1;
        host.awake(1'b1);
        repeat (4) @(posedge clk);
        host.awake(1'b0);
        wait_for(0, 1'b1);
        check("irq_wake", {7'h00, irq_out_oe}, 8'h01);
        cnt = reset_pin_oe;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (reset_pin_oe === 1'b1) cnt++;
        end
        check("pulse_len", 8'(cnt), 8'(PULSE));
        wakeup_ack = 1'b1;
        @(posedge clk);
        #1 wakeup_ack = 1'b0;
        check("wake_clear", {6'h00, wakeup_flag, irq_out_oe}, 8'h00);
        terminal_mode_en = 1'b0;
        host.awake(1'b1);
        // External reset held until core reset rises, then six more clocks
        @(posedge clk);
        #1 ext_rst = 1'b1;
        wait_for(1, 1'b1);
        repeat (6) @(posedge clk);
        #1 ext_rst = 1'b0;
        wait_for(1, 1'b0);
        results();
    end

endmodule // chp_host_port_tb

`default_nettype wire
